/* core/fbdcd_defines.svh */
// What this block does
// - Command word acts only when source is 4
// - Bit 0 requests run, else stop
// - Bit 1 forces stop on second ramp
// - Fault reset only on bit 2 rising
// - Bit 3 coasts drive, overriding run
// - Priority: coast, then fast stop, then run
// - Stop/run bits act only if terminal select 0-3
// - Terminal select above 3: terminals own start/stop
// - Reset acts with fieldbus source, any terminal select
// - Four input words taken every exchange
// - Four output words returned every exchange
// - Words 1-2 fixed; words 3-4 pass through
// - Bit rate detected automatically, 9.6k to 12M
// - Green steady in exchange, flashing when idle
// - Acyclic parameter read/write forwarded to drive
// - Station address from drive setting
// - Word 2 is signed setpoint, tenths of hertz
// - Output word 1: fault code high while tripped, else 0; status low
`ifndef FBDCD_DEFINES_SVH
`define FBDCD_DEFINES_SVH
`define FBDCD_SRC_FIELDBUS 4'h4
`define FBDCD_TERM_MAX     8'h03
`define FBDCD_BIT_RUN      0
`define FBDCD_BIT_FSTOP    1
`define FBDCD_BIT_RESET    2
`define FBDCD_BIT_COAST    3
`define FBDCD_STAT_RUN     0
`define FBDCD_STAT_TRIP    1
`define FBDCD_WORDS        4
`define FBDCD_FLASH_NS     250000000
`define FBDCD_CLK_NS       40
`define FBDCD_FLASH_CYC    (`FBDCD_FLASH_NS / `FBDCD_CLK_NS)
`endif

/* core/fbdcd_pkg.sv */
package fbdcd_pkg;
   typedef struct packed {
      logic        run;
      logic        fast_stop;
      logic        coast_stop;
      logic        fault_reset;
   } fbdcd_cmd_t;
   typedef struct packed {
      logic [7:0]  fault_code;
      logic        running;
      logic        tripped;
      logic [5:0]  other_flags;
   } fbdcd_stat_t;
   typedef enum logic [1:0] {
      FBDCD_LED_OFF, FBDCD_LED_GREEN, FBDCD_LED_RED
   } fbdcd_led_t;
endpackage

/* core/fbdcd_led.sv */
`timescale 1ns/100ps
`include "fbdcd_defines.svh"
module fbdcd_led #(
   parameter int FLASH_CYC = `FBDCD_FLASH_CYC
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               srst_i,
   input  wire logic               clk_en_i,
   // Conditions
   input  wire logic               exch_i,
   input  wire logic               net_ok_i,
   input  wire logic               param_err_i,
   input  wire logic               net_err_i,
   // Indicator
   output fbdcd_pkg::fbdcd_led_t   led_o
);
   import fbdcd_pkg::*;
   logic [31:0] tick_q;
   logic [2:0]  phase_q;
   fbdcd_led_t  led_q;
   fbdcd_led_t  led_d;
   wire         tick_w = (tick_q == 32'(FLASH_CYC - 1));
   // Eight phases: one flash uses phase 0, two use phases 0 and 2
   wire         red1_w = (phase_q == 3'h0);
   wire         red2_w = (phase_q == 3'h0) || (phase_q == 3'h2);
   always_comb begin
      if (net_err_i)
         led_d = red2_w ? FBDCD_LED_RED : FBDCD_LED_OFF;
      else if (param_err_i)
         led_d = red1_w ? FBDCD_LED_RED : FBDCD_LED_OFF;
      else if (exch_i)
         led_d = FBDCD_LED_GREEN;
      else if (net_ok_i)
         led_d = phase_q[0] ? FBDCD_LED_OFF : FBDCD_LED_GREEN;
      else
         led_d = FBDCD_LED_OFF;
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         tick_q  <= 32'h0;
         phase_q <= 3'h0;
         led_q   <= FBDCD_LED_OFF;
      end else if (clk_en_i) begin
         tick_q  <= tick_w ? 32'h0 : tick_q + 32'h1;
         if (tick_w)
            phase_q <= phase_q + 3'h1;
         led_q   <= led_d;
      end
   end
   assign led_o = led_q;
endmodule

/* core/fbdcd_top.sv */
`timescale 1ns/100ps
`include "fbdcd_defines.svh"
module fbdcd_top #(
   parameter int W         = 16,
   parameter int FLASH_CYC = `FBDCD_FLASH_CYC
) (
   // Clock, reset, enable
   input  wire logic                  ref_clk_i,
   input  wire logic                  srst_i,
   input  wire logic                  clk_en_i,
   // Drive settings
   input  wire logic [3:0]            control_source_select_i,
   input  wire logic [7:0]            terminal_function_select_i,
   input  wire logic [7:0]            station_address_setting_i,
   // Network side, words taken on exch_strobe_i
   input  wire logic                  exch_strobe_i,
   input  wire logic [4*W-1:0]        process_input_word_i,
   input  wire logic                  net_ok_i,
   input  wire logic                  net_err_i,
   input  wire logic                  param_err_i,
   input  wire logic [3:0]            baud_sel_i,
   // Acyclic parameter service from network
   input  wire logic                  acyc_req_i,
   input  wire logic                  acyc_wr_i,
   input  wire logic [15:0]           acyc_addr_i,
   input  wire logic [15:0]           acyc_wdata_i,
   // Drive feedback
   input  wire logic                  term_run_i,
   input  wire logic                  term_stop_i,
   input  fbdcd_pkg::fbdcd_stat_t     drive_status_i,
   input  wire logic [W-1:0]          out_freq_i,
   input  wire logic [W-1:0]          out_word3_i,
   input  wire logic [W-1:0]          out_word4_i,
   input  wire logic                  acyc_ack_i,
   input  wire logic [15:0]           acyc_rdata_i,
   // Drive commands
   output fbdcd_pkg::fbdcd_cmd_t      drive_cmd_o,
   output logic signed [W-1:0]        freq_setpoint_o,
   output logic [W-1:0]               user_word3_o,
   output logic [W-1:0]               user_word4_o,
   output logic                       acyc_req_o,
   output logic                       acyc_wr_o,
   output logic [15:0]                acyc_addr_o,
   output logic [15:0]                acyc_wdata_o,
   // Network answers
   output logic [4*W-1:0]             process_output_word_o,
   output logic                       acyc_done_o,
   output logic [15:0]                acyc_rdata_o,
   output logic [7:0]                 station_addr_o,
   output logic [3:0]                 baud_o,
   output logic                       exch_o,
   output fbdcd_pkg::fbdcd_led_t      led_o
);
   import fbdcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Command word decode
   logic [W-1:0]      drive_command_word_q;
   logic              reset_bit_q;
   fbdcd_cmd_t        cmd_q;
   fbdcd_cmd_t        cmd_d;
   logic signed [W-1:0] freq_q;
   logic [W-1:0]      w3_q;
   logic [W-1:0]      w4_q;
   logic [4*W-1:0]    pout_q;
   logic              exch_q;
   logic [7:0]        addr_q;
   logic [3:0]        baud_q;
   logic              areq_q;
   logic              awr_q;
   logic [15:0]       aaddr_q;
   logic [15:0]       awdata_q;
   logic              adone_q;
   logic [15:0]       ardata_q;

   wire [W-1:0] word_w [`FBDCD_WORDS];
   genvar g;
   for (g = 0; g < `FBDCD_WORDS; g++) begin : g_split
      assign word_w[g] = process_input_word_i[g*W +: W];
   end

   wire fb_src_w  = (control_source_select_i == `FBDCD_SRC_FIELDBUS);
   wire term_ok_w = (terminal_function_select_i <= `FBDCD_TERM_MAX);
   wire fb_ss_w   = fb_src_w && term_ok_w;
   // Bits above 3 are never looked at
   wire coast_w   = drive_command_word_q[`FBDCD_BIT_COAST];
   wire fstop_w   = drive_command_word_q[`FBDCD_BIT_FSTOP];
   wire runb_w    = drive_command_word_q[`FBDCD_BIT_RUN];
   wire rstb_w    = drive_command_word_q[`FBDCD_BIT_RESET];
   // Level held once per exchange: edge is between exchanges
   wire rst_edge_w = rstb_w && !reset_bit_q;

   // Terminal pins are asynchronous; a level counts once two stages agree
   logic [1:0]        term_s1_q;
   logic [1:0]        term_s2_q;
   logic [1:0]        term_s3_q;
   logic [1:0]        term_q;
   wire  [1:0]        term_agree_w = ~(term_s2_q ^ term_s3_q);
   wire  [1:0]        term_d       = (term_s2_q & term_agree_w) |
                                     (term_q & ~term_agree_w);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         term_s1_q <= 2'h0;
         term_s2_q <= 2'h0;
         term_s3_q <= 2'h0;
         term_q    <= 2'h0;
      end else if (clk_en_i) begin
         term_s1_q <= {term_stop_i, term_run_i};
         term_s2_q <= term_s1_q;
         term_s3_q <= term_s2_q;
         term_q    <= term_d;
      end
   end

   always_comb begin
      cmd_d = '0;
      if (fb_ss_w) begin
         if (coast_w)
            cmd_d.coast_stop = 1'b1;
         else if (fstop_w)
            cmd_d.fast_stop = 1'b1;
         else
            cmd_d.run = runb_w;
      end else if (!term_ok_w) begin
         // Terminals own start/stop in this mode
         cmd_d.run = term_q[0] && !term_q[1];
      end
      cmd_d.fault_reset = fb_src_w && rst_edge_w;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   wire [W-1:0] stat_w = {drive_status_i.tripped ?
                          drive_status_i.fault_code : 8'h00,
                          drive_status_i.other_flags,
                          drive_status_i.tripped,
                          drive_status_i.running};

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         drive_command_word_q <= 16'h0000;
         freq_q   <= 16'h0000;
         w3_q     <= 16'h0000;
         w4_q     <= 16'h0000;
         pout_q   <= '0;
         exch_q   <= 1'b0;
      end else if (clk_en_i) begin
         exch_q <= exch_strobe_i;
         if (exch_strobe_i) begin
            drive_command_word_q <= word_w[0];
            freq_q <= word_w[1];
            w3_q   <= word_w[2];
            w4_q   <= word_w[3];
            pout_q <= {out_word4_i, out_word3_i,
                       out_freq_i, stat_w};
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reset_bit_q <= 1'b0;
         cmd_q       <= '0;
      end else if (clk_en_i) begin
         reset_bit_q <= rstb_w;
         cmd_q       <= cmd_d;
      end
   end

   // Station address follows the drive side, detected rate follows baud_sel_i from the network side
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         addr_q <= 8'h00;
         baud_q <= 4'h0;
      end else if (clk_en_i) begin
         addr_q <= station_address_setting_i;
         baud_q <= baud_sel_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acyclic parameter access, one request outstanding
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         areq_q   <= 1'b0;
         awr_q    <= 1'b0;
         aaddr_q  <= 16'h0000;
         awdata_q <= 16'h0000;
         adone_q  <= 1'b0;
         ardata_q <= 16'h0000;
      end else if (clk_en_i) begin
         adone_q <= 1'b0;
         if (!areq_q && acyc_req_i) begin
            areq_q   <= 1'b1;
            awr_q    <= acyc_wr_i;
            aaddr_q  <= acyc_addr_i;
            awdata_q <= acyc_wdata_i;
         end else if (areq_q && acyc_ack_i) begin
            areq_q   <= 1'b0;
            adone_q  <= 1'b1;
            ardata_q <= acyc_rdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicator
   fbdcd_led #(
      .FLASH_CYC   (FLASH_CYC)
   ) u_led (
      .ref_clk_i   (ref_clk_i),
      .srst_i      (srst_i),
      .clk_en_i    (clk_en_i),
      .exch_i      (exch_q),
      .net_ok_i    (net_ok_i),
      .param_err_i (param_err_i),
      .net_err_i   (net_err_i),
      .led_o       (led_o)
   );

   assign drive_cmd_o           = cmd_q;
   assign freq_setpoint_o       = freq_q;
   assign user_word3_o          = w3_q;
   assign user_word4_o          = w4_q;
   assign process_output_word_o = pout_q;
   assign exch_o                = exch_q;
   assign station_addr_o        = addr_q;
   assign baud_o                = baud_q;
   assign acyc_req_o            = areq_q;
   assign acyc_wr_o             = awr_q;
   assign acyc_addr_o           = aaddr_q;
   assign acyc_wdata_o          = awdata_q;
   assign acyc_done_o           = adone_q;
   assign acyc_rdata_o          = ardata_q;
endmodule

/* testbench/fbdcd_top_asserts.sv */
`timescale 1ns/100ps
module fbdcd_top_asserts #(parameter int W = 16) (
   // Clock and settings
   input wire logic                 ref_clk_i,
   input wire logic                 srst_i,
   input wire logic                 clk_en_i,
   input wire logic [3:0]           control_source_select_i,
   input wire logic [7:0]           terminal_function_select_i,
   input wire logic [7:0]           station_address_setting_i,
   input wire logic [3:0]           baud_sel_i,
   input wire logic                 net_err_i,
   input wire logic                 param_err_i,
   // Network and drive inputs
   input wire logic                 exch_strobe_i,
   input wire logic [4*W-1:0]       process_input_word_i,
   input wire logic [W-1:0]         out_freq_i,
   input wire logic [W-1:0]         out_word3_i,
   input wire logic [W-1:0]         out_word4_i,
   input fbdcd_pkg::fbdcd_stat_t    drive_status_i,
   input wire logic                 acyc_req_i,
   input wire logic                 acyc_wr_i,
   input wire logic [15:0]          acyc_addr_i,
   input wire logic [15:0]          acyc_wdata_i,
   input wire logic                 acyc_ack_i,
   input wire logic [15:0]          acyc_rdata_i,
   // Outputs
   input fbdcd_pkg::fbdcd_cmd_t     drive_cmd_o,
   input wire logic signed [W-1:0]  freq_setpoint_o,
   input wire logic [W-1:0]         user_word3_o,
   input wire logic [W-1:0]         user_word4_o,
   input wire logic [4*W-1:0]       process_output_word_o,
   input wire logic                 exch_o,
   input wire logic [7:0]           station_addr_o,
   input wire logic [3:0]           baud_o,
   input wire logic                 acyc_req_o,
   input wire logic                 acyc_wr_o,
   input wire logic [15:0]          acyc_addr_o,
   input wire logic [15:0]          acyc_wdata_o,
   input wire logic                 acyc_done_o,
   input wire logic [15:0]          acyc_rdata_o,
   input fbdcd_pkg::fbdcd_led_t     led_o
);
   import fbdcd_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   logic tk, gate, tm;
   // Settings checked over three cycles, decode lags the strobe
   assign tk = exch_strobe_i && clk_en_i;
   assign tm = terminal_function_select_i > 8'h03;
   assign gate = control_source_select_i != 4'h4 && !tm;
   //////////////////////////////////////////////////////////////////////
   exch_echo_a: assert property (tk |=> exch_o)
      else $error("exchange not echoed");
   setpoint_take_a: assert property (tk |=>
      freq_setpoint_o == $past(process_input_word_i[2*W-1:W]))
      else $error("setpoint not taken");
   user_words_a: assert property (tk |=>
      {user_word4_o, user_word3_o} == $past(process_input_word_i[4*W-1:2*W]))
      else $error("user words not taken");
   out_words_a: assert property (tk |=>
      process_output_word_o[4*W-1:W] ==
      $past({out_word4_i, out_word3_i, out_freq_i}))
      else $error("output words wrong");
   coast_first_a: assert property (drive_cmd_o.coast_stop |->
      !drive_cmd_o.run && !drive_cmd_o.fast_stop) else $error("coast lost");
   fast_over_run_a: assert property (drive_cmd_o.fast_stop |->
      !drive_cmd_o.run) else $error("run beat fast stop");
   reset_pulse_a: assert property (drive_cmd_o.fault_reset && clk_en_i
      |=> !drive_cmd_o.fault_reset) else $error("reset pulse too long");
   reset_source_a: assert property (drive_cmd_o.fault_reset |->
      $past(control_source_select_i) == 4'h4) else $error("reset no source");
   source_gate_a: assert property (gate && $past(gate) &&
      $past(gate, 2) |-> !drive_cmd_o.run && !drive_cmd_o.coast_stop)
      else $error("command acted without fieldbus source");
   term_owns_a: assert property (tm && $past(tm) && $past(tm, 2) |->
      !drive_cmd_o.fast_stop && !drive_cmd_o.coast_stop)
      else $error("bus stop bits acted in terminal mode");
   status_word_a: assert property (tk |=>
      process_output_word_o[1:0] ==
      $past({drive_status_i.tripped, drive_status_i.running}) &&
      (!$past(drive_status_i.tripped) ||
      process_output_word_o[15:8] == $past(drive_status_i.fault_code)))
      else $error("status word wrong");
   addr_follow_a: assert property (!$past(srst_i) && $past(clk_en_i)
      |-> station_addr_o == $past(station_address_setting_i) &&
      baud_o == $past(baud_sel_i)) else $error("address or rate lost");
   acyc_take_a: assert property (!srst_i && clk_en_i && acyc_req_i &&
      !acyc_req_o |=> acyc_req_o && acyc_wr_o == $past(acyc_wr_i) &&
      acyc_addr_o == $past(acyc_addr_i) &&
      acyc_wdata_o == $past(acyc_wdata_i)) else $error("request not taken");
   acyc_done_a: assert property (clk_en_i && acyc_req_o && acyc_ack_i
      |=> !acyc_req_o && acyc_done_o && acyc_rdata_o == $past(acyc_rdata_i))
      else $error("answer not returned");
   led_green_a: assert property ($past(exch_o) && !$past(srst_i) &&
      $past(clk_en_i) && !$past(net_err_i) && !$past(param_err_i) |->
      led_o == FBDCD_LED_GREEN) else $error("green not steady");
   led_error_a: assert property ($past(net_err_i) &&
      $past(clk_en_i) |-> led_o != FBDCD_LED_GREEN)
      else $error("green shown on network error");
   cover property (tk);
   cover property (acyc_done_o);
   cover property (drive_cmd_o.fault_reset);
   cover property (drive_cmd_o.coast_stop);
endmodule
bind fbdcd_top fbdcd_top_asserts #(.W(W)) u_chk (.ref_clk_i, .srst_i,
   .clk_en_i, .control_source_select_i, .terminal_function_select_i,
   .station_address_setting_i, .baud_sel_i, .net_err_i, .param_err_i,
   .exch_strobe_i, .process_input_word_i, .out_freq_i, .out_word3_i,
   .out_word4_i, .drive_status_i, .acyc_req_i, .acyc_wr_i, .acyc_addr_i,
   .acyc_wdata_i, .acyc_ack_i, .acyc_rdata_i, .drive_cmd_o,
   .freq_setpoint_o, .user_word3_o, .user_word4_o, .process_output_word_o,
   .exch_o, .station_addr_o, .baud_o, .acyc_req_o, .acyc_wr_o, .acyc_addr_o,
   .acyc_wdata_o, .acyc_done_o, .acyc_rdata_o, .led_o);

/* testbench/fbdcd_master_model.sv */
`timescale 1ns/100ps
module fbdcd_master_model (
   // Clock
   input  wire logic         ref_clk_i,
   // Bench requests
   input  wire logic         send_i,
   input  wire logic [63:0]  word_i,
   // Toward the option module
   output logic              exch_strobe_o,
   output logic [63:0]       word_o
);
   initial exch_strobe_o = 1'b0;
   initial word_o = 64'h0;
   // Idle words toggle so stale data is never mistaken for new
   always @(posedge ref_clk_i) begin
      exch_strobe_o <= send_i;
      word_o <= send_i ? word_i : ~word_o;
   end
endmodule

/* testbench/fieldbus_drive_command_decoder_test.sv */
`timescale 1ns/100ps
module fieldbus_drive_command_decoder_test;
   import fbdcd_pkg::*;
   typedef struct packed {
      fbdcd_cmd_t   cmd;
      logic [15:0]  sp;
   } fbdcd_exp_t;
   logic               ref_clk = 1'b0;
   logic               srst = 1'b1;
   logic               send = 1'b0;
   logic               trun = 1'b0;
   logic               tstop = 1'b0;
   logic               b2 = 1'b0;
   logic               seen = 1'b0;
   logic [3:0]         src = 4'h0;
   logic [7:0]         tfs = 8'h00;
   logic [63:0]        word = 64'h0;
   logic [94:0]        rnd = '0;
   wire                strobe;
   wire [63:0]         piw;
   fbdcd_cmd_t         cmd;
   logic signed [15:0] sp;
   logic               exch;
   fbdcd_exp_t         held;
   fbdcd_exp_t         q[$];
   int                 n_errors = 0;
   int                 tests_run = 0;
   int                 seed = 32'h06ECF66D;
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) rnd <= 95'({$random(seed), $random(seed),
      $random(seed)});
   fbdcd_master_model master (.ref_clk_i(ref_clk), .send_i(send),
      .word_i(word), .exch_strobe_o(strobe), .word_o(piw));
   fbdcd_top #(.FLASH_CYC(4)) uut (.ref_clk_i(ref_clk), .srst_i(srst),
      .clk_en_i(1'b1), .control_source_select_i(src),
      .terminal_function_select_i(tfs), .station_address_setting_i(rnd[94:87]),
      .exch_strobe_i(strobe), .process_input_word_i(piw),
      .net_ok_i(rnd[82]), .net_err_i(rnd[81]), .param_err_i(rnd[80]),
      .baud_sel_i(rnd[86:83]), .acyc_req_i(rnd[1]), .acyc_wr_i(rnd[2]),
      .acyc_addr_i(rnd[47:32]), .acyc_wdata_i(rnd[63:48]), .term_run_i(trun),
      .term_stop_i(tstop), .drive_status_i(fbdcd_stat_t'(rnd[79:64])),
      .out_freq_i(rnd[63:48]), .out_word3_i(rnd[47:32]),
      .out_word4_i(rnd[31:16]), .acyc_ack_i(rnd[16]),
      .acyc_rdata_i(rnd[15:0]), .drive_cmd_o(cmd), .freq_setpoint_o(sp),
      .user_word3_o(), .user_word4_o(), .acyc_req_o(), .acyc_wr_o(),
      .acyc_addr_o(), .acyc_wdata_o(), .process_output_word_o(),
      .acyc_done_o(), .acyc_rdata_o(), .station_addr_o(), .baud_o(),
      .exch_o(exch), .led_o());
   //////////////////////////////////////////////////////////////////////
   function automatic fbdcd_cmd_t expect_cmd(input logic [15:0] c);
      fbdcd_cmd_t e;
      e = '0;
      if (tfs > 8'h03) e.run = trun & ~tstop;
      else if (src == 4'h4) begin
         e.coast_stop = c[3];
         e.fast_stop = c[1] & ~c[3];
         e.run = c[0] & ~c[1] & ~c[3];
      end
      e.fault_reset = (src == 4'h4) & c[2] & ~b2;
      return e;
   endfunction
   task automatic xfer(input logic [15:0] c);
      logic [63:0] w;
      w = {$random(seed), $random(seed)};
      w[15:0] = c;
      q.push_back({expect_cmd(c), w[31:16]});
      b2 = c[2];
      send <= 1'b1;
      word <= w;
      @(posedge ref_clk);
   endtask
   // Quiet gap both before and after settings move, so decode never straddles
   task automatic settle(input logic [31:0] r);
      send <= 1'b0;
      repeat (4) @(posedge ref_clk);
      src <= r[0] ? 4'h4 : r[7:4];
      tfs <= r[1] ? {6'h00, r[9:8]} : 8'h04 | r[23:16];
      trun <= r[2];
      tstop <= r[3];
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic check_cmd(input fbdcd_cmd_t e);
      tests_run++;
      if (cmd !== e) begin
         n_errors++;
         $display("wrong value %0t cmd %b exp %b", $time, cmd, e);
      end
   endtask
   task automatic check_sp(input logic [15:0] e);
      tests_run++;
      if (sp !== e) begin
         n_errors++;
         $display("wrong value %0t setpoint %h exp %h", $time, sp, e);
      end
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(negedge ref_clk) begin
      if (seen) check_cmd(held.cmd);
      seen = (exch === 1'b1);
      if (seen) begin
         held = q.pop_front();
         check_sp(held.sp);
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      settle(32'h0000_0303);
      for (int i = 0; i < 16; i++) xfer(i[15:0] | 16'($random(seed)) & 16'hFFF0);
      for (int g = 0; g < 12; g++) begin
         settle(g == 0 ? 32'h1 : $random(seed));
         repeat (6) xfer(16'($random(seed)));
      end
      settle(32'h0);
      print_verdict();
   end
   initial begin
      #40000;
      n_errors++;
      print_verdict();
   end
endmodule
